// ---- usart_ctrl_pkg.sv ----
package usart_ctrl_pkg;

    // Register addresses
    localparam logic [5:0] ADDR_STATUS = 6'h0b;
    localparam logic [5:0] ADDR_ENABLE = 6'h0a;
    localparam logic [5:0] ADDR_FORMAT = 6'h03;
    localparam logic [5:0] ADDR_BAUD_LO = 6'h09;
    localparam logic [5:0] ADDR_BAUD_HI = 6'h02;
    localparam logic [5:0] ADDR_DATA = 6'h0c;

    // Enable register bits
    localparam int EN_RXIE = 7;
    localparam int EN_TXIE = 6;
    localparam int EN_UEIE = 5;
    localparam int EN_RX = 4;
    localparam int EN_TX = 3;
    localparam int EN_SZ2 = 2;
    localparam int EN_RB8 = 1;
    localparam int EN_TB8 = 0;

    // Status register bits
    localparam int ST_RXD = 7;
    localparam int ST_TXD = 6;
    localparam int ST_UE = 5;
    localparam int ST_FE = 4;
    localparam int ST_OVR = 3;
    localparam int ST_PE = 2;

    localparam logic [7:0] FORMAT_RESET = 8'h06;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [3:0] BAUD_HI_MASK = 4'hf;

    typedef enum logic [1:0] {
        MODE_ASYNC = 2'h0,
        MODE_SYNC = 2'h1,
        MODE_RSVD = 2'h2,
        MODE_MSPI = 2'h3
    } operating_mode_t;

    typedef enum logic [1:0] {
        PAR_OFF = 2'h0,
        PAR_RSVD = 2'h1,
        PAR_EVEN = 2'h2,
        PAR_ODD = 2'h3
    } parity_mode_t;

    // Character sizes; 9 bits is code 7
    localparam logic [2:0] CSZ_9 = 3'h7;
    localparam logic [3:0] CSZ_BASE = 4'h5;
    localparam logic [3:0] CSZ_NINE = 4'h9;

    // Received character with its error flags
    typedef struct packed {
        logic [8:0] data;
        logic frame_err;
        logic parity_err;
    } rx_char_t;

    // Frame setting handed to the shifter
    typedef struct packed {
        operating_mode_t mode;
        parity_mode_t parity;
        logic two_stop;
        logic [3:0] data_bits;
        logic tx_change_falling;
        logic rx_sample_rising;
    } frame_cfg_t;

endpackage

// ---- rx_char_buffer.sv ----
`timescale 1ns/10ps
`default_nettype none
module rx_char_buffer
    import usart_ctrl_pkg::*;
#(
    parameter int DEPTH = 2
)
(
    input wire logic sys_clk, // System clock
    input wire logic rst, // Async reset
    input wire logic flush, // Drop all entries
    input wire logic push, // Store a character
    input wire rx_char_t push_char, // Character to store
    input wire logic pop, // Release the head
    output rx_char_t head_r, // Head entry, registered
    output logic not_empty_r, // At least one entry
    output logic full // No room left
);

    localparam int AW = $clog2(DEPTH + 1);

    rx_char_t mem_r [DEPTH];
    logic [AW-1:0] count_r;
    logic do_push;
    logic do_pop;

    assign full = (count_r == AW'(DEPTH));
    assign do_push = push && (!full || pop);
    assign do_pop = pop && (count_r != '0);

    // Shift-down store keeps the head always at entry 0
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_ent
            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                    mem_r[g] <= '0;
                else if (do_push && (AW'(g) == (count_r - AW'(do_pop))))
                    mem_r[g] <= push_char;
                else if (do_pop && (g < DEPTH - 1))
                    mem_r[g] <= mem_r[(g < DEPTH - 1) ? g + 1 : g];
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            count_r <= '0;
        else if (flush)
            count_r <= '0;
        else
            count_r <= count_r + AW'(do_push) - AW'(do_pop);
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            head_r <= '0;
        else if (do_pop && count_r > AW'(1))
            head_r <= mem_r[1 % DEPTH];
        else if (do_push && (count_r == '0 || (do_pop && count_r == AW'(1))))
            head_r <= push_char;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            not_empty_r <= 1'b0;
        else if (flush)
            not_empty_r <= 1'b0;
        else
            not_empty_r <= (count_r + AW'(do_push) - AW'(do_pop)) != '0;
    end

endmodule
`default_nettype wire

// ---- parity_calc.sv ----
`timescale 1ns/10ps
`default_nettype none
module parity_calc
    import usart_ctrl_pkg::*;
(
    input wire logic [8:0] data, // Data bits, unused upper bits zero
    input wire parity_mode_t mode, // Parity mode
    output logic parity // Bit to send or expect
);

    // Odd parity inverts the even sum
    assign parity = (^data) ^ (mode == PAR_ODD);

endmodule
`default_nettype wire

// ---- usart_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module usart_ctrl
    import usart_ctrl_pkg::*;
#(
    parameter int RX_DEPTH = 2
)
(
    input wire logic sys_clk, // System clock, 25 MHz
    input wire logic rst, // Async reset, active high
    input wire logic [5:0] io_addr, // CPU I/O register address
    input wire logic io_wr, // Register write strobe
    input wire logic io_rd, // Register read strobe
    input wire logic [7:0] io_wdata, // Write data
    output logic [7:0] io_rdata, // Read data, registered
    input wire logic global_irq_enable, // CPU global interrupt flag
    input wire logic rx_done_irq_ack, // Receive-complete vector taken
    input wire logic tx_done_irq_ack, // Transmit-complete vector taken
    input wire logic buffer_empty_irq_ack, // Data-empty vector taken
    output logic rx_done_irq, // Receive-complete request
    output logic tx_done_irq, // Transmit-complete request
    output logic buffer_empty_irq, // Data-empty request
    output frame_cfg_t frame_cfg, // Frame settings to shifter
    output logic [11:0] baud_divisor, // Baud divisor to prescaler
    output logic baud_reload, // One-cycle prescaler reload
    output logic rx_pin_override, // Receiver owns RxD
    output logic tx_pin_override, // Transmitter owns TxD
    input wire logic tx_load_ready, // Shifter accepts next character
    output logic tx_load, // Hand character to shifter
    output logic [8:0] tx_char, // Character with parity source
    output logic tx_parity, // Parity bit to append
    input wire logic tx_shift_busy, // Shift register holds a frame
    input wire logic tx_frame_end, // Last stop bit sent
    input wire logic rx_char_valid, // Received character pulse
    input wire logic [8:0] rx_char_data, // Received data bits
    input wire logic rx_stop_bit, // First stop bit value
    input wire logic rx_parity_bit, // Received parity bit
    input wire logic rx_start_seen // New start bit detected
);

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] enable_r;
    logic [7:0] format_r;
    logic [3:0] baud_hi_r;
    logic [7:0] baud_lo_r;
    logic tx_active_r;
    logic [8:0] tx_buf_r;
    logic tx_buf_full_r;
    logic tx_done_r;
    logic overrun_r;
    logic rx_pending_r;
    logic wr_enable;
    logic wr_format;
    logic rd_data;
    logic wr_data;
    logic [8:0] rx_masked;
    logic [8:0] tx_masked;
    logic rx_par_exp;
    logic [2:0] csz;
    rx_char_t rx_in;
    rx_char_t rx_head;
    logic rx_not_empty;
    logic rx_full;

    assign wr_enable = io_wr && (io_addr == ADDR_ENABLE);
    assign wr_format = io_wr && (io_addr == ADDR_FORMAT);
    assign rd_data = io_rd && (io_addr == ADDR_DATA);
    assign wr_data = io_wr && (io_addr == ADDR_DATA);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            enable_r <= ENABLE_RESET;
        else if (wr_enable)
            enable_r <= {io_wdata[7:2], 1'b0, io_wdata[EN_TB8]};
    end

    // Disabling the transmitter waits for buffer and shifter to drain
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            tx_active_r <= 1'b0;
        else if (enable_r[EN_TX])
            tx_active_r <= 1'b1;
        else if (!tx_buf_full_r && !tx_shift_busy && !tx_load)
            tx_active_r <= 1'b0;
    end

    assign tx_pin_override = tx_active_r;
    assign rx_pin_override = enable_r[EN_RX];

    // Upper mode bit is read-only
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            format_r <= FORMAT_RESET;
        else if (wr_format)
            format_r <= {format_r[7], io_wdata[6:0]};
    end

    // ------------------------------------------------------------
    // Baud divisor
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            baud_hi_r <= '0;
        else if (io_wr && io_addr == ADDR_BAUD_HI)
            baud_hi_r <= io_wdata[3:0] & BAUD_HI_MASK;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            baud_lo_r <= '0;
        else if (io_wr && io_addr == ADDR_BAUD_LO)
            baud_lo_r <= io_wdata;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            baud_reload <= 1'b0;
        else
            baud_reload <= io_wr && (io_addr == ADDR_BAUD_LO);
    end

    assign baud_divisor = {baud_hi_r, baud_lo_r};

    // ------------------------------------------------------------
    // Frame settings
    // ------------------------------------------------------------
    assign csz = {enable_r[EN_SZ2], format_r[2:1]};

    always_comb
    begin
        frame_cfg.mode = operating_mode_t'(format_r[7:6]);
        frame_cfg.parity = parity_mode_t'(format_r[5:4]);
        frame_cfg.two_stop = format_r[3];
        if (csz == CSZ_9)
            frame_cfg.data_bits = CSZ_NINE;
        else if (!csz[2])
            frame_cfg.data_bits = CSZ_BASE + {2'h0, csz[1:0]};
        else
            frame_cfg.data_bits = CSZ_BASE + 4'h3;
        // Polarity only matters in synchronous mode
        frame_cfg.tx_change_falling = format_r[0] && (format_r[7:6] == MODE_SYNC);
        frame_cfg.rx_sample_rising = format_r[0] && (format_r[7:6] == MODE_SYNC);
    end

    // ------------------------------------------------------------
    // Transmit buffer
    // ------------------------------------------------------------
    // Writes while the buffer is full are ignored
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            tx_buf_r <= '0;
        else if (wr_data && !tx_buf_full_r)
            tx_buf_r <= {enable_r[EN_TB8], io_wdata};
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            tx_buf_full_r <= 1'b0;
        else if (wr_data && !tx_buf_full_r)
            tx_buf_full_r <= 1'b1;
        else if (tx_load)
            tx_buf_full_r <= 1'b0;
    end

    assign tx_load = tx_buf_full_r && tx_active_r && tx_load_ready;
    assign tx_char = tx_buf_r;
    assign tx_masked = tx_buf_r & ~(9'h1ff << frame_cfg.data_bits);

    parity_calc u_tx_par (
        .data(tx_masked),
        .mode(parity_mode_t'(format_r[5:4])),
        .parity(tx_parity)
    );

    // Set wins over a same-cycle clear
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            tx_done_r <= 1'b0;
        else if (tx_frame_end && !tx_buf_full_r)
            tx_done_r <= 1'b1;
        else if (tx_done_irq_ack)
            tx_done_r <= 1'b0;
        else if (io_wr && io_addr == ADDR_STATUS && io_wdata[ST_TXD])
            tx_done_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------
    always_comb
    begin
        rx_masked = '0;
        for (int i = 0; i < 9; i++)
            rx_masked[i] = rx_char_data[i] && (4'(i) < frame_cfg.data_bits);
    end

    parity_calc u_rx_par (
        .data(rx_masked),
        .mode(parity_mode_t'(format_r[5:4])),
        .parity(rx_par_exp)
    );

    always_comb
    begin
        rx_in.data = rx_masked;
        rx_in.frame_err = !rx_stop_bit;
        rx_in.parity_err = format_r[5] && (rx_par_exp != rx_parity_bit);
    end

    rx_char_buffer #(
        .DEPTH(RX_DEPTH)
    ) u_rx_buf (
        .sys_clk(sys_clk),
        .rst(rst),
        .flush(!enable_r[EN_RX]),
        .push(rx_char_valid && enable_r[EN_RX]),
        .push_char(rx_in),
        .pop(rd_data),
        .head_r(rx_head),
        .not_empty_r(rx_not_empty),
        .full(rx_full)
    );

    // A character waits in the shifter once the buffer is full
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rx_pending_r <= 1'b0;
        else if (!enable_r[EN_RX] || rd_data)
            rx_pending_r <= 1'b0;
        else if (rx_char_valid && rx_full)
            rx_pending_r <= 1'b1;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            overrun_r <= 1'b0;
        else if (rx_pending_r && rx_full && rx_start_seen && enable_r[EN_RX])
            overrun_r <= 1'b1;
        else if (rd_data || !enable_r[EN_RX])
            overrun_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------
    assign rx_done_irq = enable_r[EN_RXIE] && global_irq_enable && rx_not_empty;
    assign tx_done_irq = enable_r[EN_TXIE] && global_irq_enable && tx_done_r;
    assign buffer_empty_irq = enable_r[EN_UEIE] && global_irq_enable && !tx_buf_full_r;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            io_rdata <= '0;
        else if (io_rd)
        begin
            unique case (io_addr)
                ADDR_STATUS: io_rdata <= {rx_not_empty, tx_done_r, !tx_buf_full_r,
                                          rx_not_empty && rx_head.frame_err, overrun_r,
                                          rx_not_empty && rx_head.parity_err, 2'h0};
                ADDR_ENABLE: io_rdata <= {enable_r[7:2], rx_head.data[8], enable_r[EN_TB8]};
                ADDR_FORMAT: io_rdata <= format_r;
                ADDR_BAUD_HI: io_rdata <= {4'h0, baud_hi_r};
                ADDR_BAUD_LO: io_rdata <= baud_lo_r;
                ADDR_DATA: io_rdata <= rx_head.data[7:0];
                default: io_rdata <= '0;
            endcase
        end
    end

endmodule
`default_nettype wire

// ---- usart_ctrl_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module usart_ctrl_sva
    import usart_ctrl_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic rst, // Async reset
    input wire logic [5:0] io_addr, // Register address
    input wire logic io_wr, // Write strobe
    input wire logic [7:0] io_wdata, // Write data
    input wire logic global_irq_enable, // Global flag
    input wire logic rx_done_irq, // Rx irq
    input wire logic tx_done_irq, // Tx irq
    input wire logic buffer_empty_irq, // Empty irq
    input wire frame_cfg_t frame_cfg, // Frame settings
    input wire logic [11:0] baud_divisor, // Divisor
    input wire logic baud_reload, // Reload pulse
    input wire logic rx_pin_override, // RxD owned
    input wire logic tx_pin_override, // TxD owned
    input wire logic tx_load_ready, // Shifter ready
    input wire logic tx_load, // Load pulse
    input wire logic tx_shift_busy // Shifter busy
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_reg_wr(logic [5:0] a);
        io_wr && io_addr == a;
    endsequence
    property p_baud_reload;
        s_reg_wr(ADDR_BAUD_LO) |=> baud_reload && baud_divisor[7:0] == $past(io_wdata) ##1 !baud_reload || $past(io_wr);
    endproperty
    a_baud_reload: assert property (p_baud_reload) else $error("reload after low write");
    property p_reload_cause;
        baud_reload |-> $past(io_wr) && $past(io_addr) == ADDR_BAUD_LO;
    endproperty
    a_reload_cause: assert property (p_reload_cause) else $error("reload without low write");
    property p_baud_hi;
        s_reg_wr(ADDR_BAUD_HI) |=> baud_divisor[11:8] == $past(io_wdata[3:0]);
    endproperty
    a_baud_hi: assert property (p_baud_hi) else $error("baud high bits wrong");
    property p_baud_hold;
        !io_wr |=> $stable(baud_divisor);
    endproperty
    a_baud_hold: assert property (p_baud_hold) else $error("baud changed without write");
    property p_rx_irq;
        rx_done_irq |-> global_irq_enable;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx irq, global low");
    property p_tx_irq;
        tx_done_irq |-> global_irq_enable;
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx irq, global low");
    property p_empty_irq;
        buffer_empty_irq |-> global_irq_enable;
    endproperty
    a_empty_irq: assert property (p_empty_irq) else $error("empty irq, global low");
    property p_rx_override;
        s_reg_wr(ADDR_ENABLE) |=> rx_pin_override == $past(io_wdata[EN_RX]);
    endproperty
    a_rx_override: assert property (p_rx_override) else $error("rx override wrong");
    property p_tx_hold;
        tx_pin_override && tx_shift_busy |=> tx_pin_override;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx override dropped");
    property p_tx_load;
        tx_load |-> tx_load_ready;
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("load while shifter not ready");
    property p_format;
        s_reg_wr(ADDR_FORMAT) |=> frame_cfg.two_stop == $past(io_wdata[3]) && frame_cfg.parity == $past(io_wdata[5:4]);
    endproperty
    a_format: assert property (p_format) else $error("format fields wrong");
    property p_polarity;
        frame_cfg.mode != MODE_SYNC |-> !frame_cfg.tx_change_falling && !frame_cfg.rx_sample_rising;
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity outside sync mode");
endmodule
bind usart_ctrl usart_ctrl_sva u_sva (.sys_clk(sys_clk), .rst(rst), .io_addr(io_addr),
    .io_wr(io_wr), .io_wdata(io_wdata), .global_irq_enable(global_irq_enable), .rx_done_irq(rx_done_irq),
    .tx_done_irq(tx_done_irq), .buffer_empty_irq(buffer_empty_irq), .frame_cfg(frame_cfg),
    .baud_divisor(baud_divisor), .baud_reload(baud_reload), .rx_pin_override(rx_pin_override),
    .tx_pin_override(tx_pin_override), .tx_load_ready(tx_load_ready), .tx_load(tx_load),
    .tx_shift_busy(tx_shift_busy));
`default_nettype wire

// ---- usart_far_end.sv ----
`timescale 1ns/10ps
`default_nettype none
module usart_far_end
    import usart_ctrl_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic rst, // Async reset
    input wire logic tx_load, // Load pulse
    input wire logic [8:0] tx_char, // Character to send
    input wire frame_cfg_t frame_cfg, // Frame settings
    input wire logic inject, // Deliver a character
    input wire logic [8:0] inject_data, // Character bits
    input wire logic inject_bad_parity, // Corrupt its parity
    output logic tx_load_ready, // Accepts a character
    output logic tx_shift_busy, // Frame on the line
    output logic tx_frame_end, // Last stop bit out
    output logic rx_char_valid, // Character pulse
    output logic [8:0] rx_char_data, // Character bits
    output logic rx_stop_bit, // Stop bit seen
    output logic rx_parity_bit, // Parity bit seen
    output logic rx_start_seen, // Start bit pulse
    output logic [8:0] last_tx_char // Last character sent
);
    // ----------------------------------------
    // Shifter stand-in
    // ----------------------------------------
    logic [7:0] cnt_r;
    logic pend_r;
    logic [8:0] data_r;
    logic bad_r;
    assign tx_load_ready = !tx_shift_busy;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            {tx_shift_busy, tx_frame_end, cnt_r, last_tx_char} <= 19'h00000;
        else
        begin
            tx_frame_end <= 1'b0;
            if (tx_load && !tx_shift_busy)
            begin
                tx_shift_busy <= 1'b1;
                last_tx_char <= tx_char;
                // Start, data, parity and stop slots, one cycle each
                cnt_r <= 8'h02 + 8'(frame_cfg.data_bits) + 8'(frame_cfg.two_stop) + 8'(frame_cfg.parity[1]);
            end
            else if (tx_shift_busy)
            begin
                cnt_r <= cnt_r - 8'h01;
                if (cnt_r == 8'h01)
                begin
                    tx_shift_busy <= 1'b0;
                    tx_frame_end <= 1'b1;
                end
            end
        end
    end
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            {pend_r, rx_char_valid, rx_start_seen, bad_r, data_r, rx_char_data, rx_stop_bit, rx_parity_bit} <= 24'h000000;
        else
        begin
            rx_start_seen <= inject;
            pend_r <= inject;
            rx_char_valid <= pend_r;
            if (inject)
            begin
                data_r <= inject_data;
                bad_r <= inject_bad_parity;
            end
            if (pend_r)
            begin
                rx_char_data <= data_r;
                rx_stop_bit <= 1'b1;
                rx_parity_bit <= ^data_r ^ frame_cfg.parity[0] ^ bad_r;
            end
            else
            begin
                // Toggle so stale values never pass
                rx_char_data <= ~rx_char_data;
                rx_stop_bit <= ~rx_stop_bit;
                rx_parity_bit <= ~rx_parity_bit;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import usart_ctrl_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, global_irq_enable = 1'b0, tx_ack = 1'b0;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00, io_rdata;
    logic rx_done_irq, tx_done_irq, buffer_empty_irq, baud_reload, rx_pin_override, tx_pin_override;
    logic tx_load_ready, tx_load, tx_parity, tx_shift_busy, tx_frame_end, rx_char_valid, rx_stop_bit;
    logic rx_parity_bit, rx_start_seen, inject = 1'b0, inject_bad = 1'b0;
    logic [8:0] tx_char, rx_char_data, last_tx_char, inject_data = 9'h000;
    logic [11:0] baud_divisor;
    frame_cfg_t frame_cfg;
    int failures = 0, total_checks = 0;
    logic [7:0] fmt_tab [5] = '{8'h00, 8'h2a, 8'h34, 8'h06, 8'h26};
    always #20 sys_clk = ~sys_clk;
    usart_ctrl dut (.sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .global_irq_enable(global_irq_enable), .rx_done_irq_ack(1'b0),
        .tx_done_irq_ack(tx_ack), .buffer_empty_irq_ack(1'b0), .rx_done_irq(rx_done_irq), .tx_done_irq(tx_done_irq),
        .buffer_empty_irq(buffer_empty_irq), .frame_cfg(frame_cfg), .baud_divisor(baud_divisor),
        .baud_reload(baud_reload), .rx_pin_override(rx_pin_override), .tx_pin_override(tx_pin_override),
        .tx_load_ready(tx_load_ready), .tx_load(tx_load), .tx_char(tx_char), .tx_parity(tx_parity),
        .tx_shift_busy(tx_shift_busy), .tx_frame_end(tx_frame_end), .rx_char_valid(rx_char_valid),
        .rx_char_data(rx_char_data), .rx_stop_bit(rx_stop_bit), .rx_parity_bit(rx_parity_bit),
        .rx_start_seen(rx_start_seen));
    usart_far_end far (.sys_clk(sys_clk), .rst(rst), .tx_load(tx_load), .tx_char(tx_char), .frame_cfg(frame_cfg),
        .inject(inject), .inject_data(inject_data), .inject_bad_parity(inject_bad), .tx_load_ready(tx_load_ready),
        .tx_shift_busy(tx_shift_busy), .tx_frame_end(tx_frame_end), .rx_char_valid(rx_char_valid),
        .rx_char_data(rx_char_data), .rx_stop_bit(rx_stop_bit), .rx_parity_bit(rx_parity_bit),
        .rx_start_seen(rx_start_seen), .last_tx_char(last_tx_char));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic finish_test();
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge sys_clk);
        io_wr <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input string what, input logic [5:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge sys_clk);
        io_rd <= 1'b0;
        #1 chk(what, {4'h0, exp}, {4'h0, io_rdata});
    endtask
    // Bounded wait: 0 tx done, 1 TxD release
    task automatic wait_for(input int which);
        for (int i = 0; i < 300; i++)
        begin
            @(posedge sys_clk);
            #1;
            if (which == 0 ? tx_done_irq === 1'b1 : tx_pin_override === 1'b0)
                return;
        end
        chk("wait bound", 12'h000, 12'h001);
        finish_test();
    endtask
    task automatic send_in(input logic [8:0] d, input logic bad);
        @(posedge sys_clk);
        inject <= 1'b1;
        inject_data <= d;
        inject_bad <= bad;
        @(posedge sys_clk);
        inject <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk("format reset", ADDR_FORMAT, FORMAT_RESET);
        rdchk("enable reset", ADDR_ENABLE, ENABLE_RESET);
        rdchk("status reset", ADDR_STATUS, 8'h20);
        rdchk("unmapped", 6'h3f, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            wr(ADDR_ENABLE, (i == 4) ? 8'h04 : 8'h00);
            wr(ADDR_FORMAT, fmt_tab[i]);
            chk("data bits", 12'(4'(i) + 4'h5), 12'(frame_cfg.data_bits));
            chk("parity", 12'(fmt_tab[i][5:4]), 12'(frame_cfg.parity));
            chk("two stop", 12'(fmt_tab[i][3]), 12'(frame_cfg.two_stop));
        end
        wr(ADDR_FORMAT, 8'h47);
        chk("sync mode", 12'(MODE_SYNC), 12'(frame_cfg.mode));
        chk("sync edges", 12'h003, {10'h000, frame_cfg.tx_change_falling, frame_cfg.rx_sample_rising});
        wr(ADDR_FORMAT, 8'h06);
        chk("async mode", 12'(MODE_ASYNC), 12'(frame_cfg.mode));
        wr(ADDR_BAUD_HI, 8'h0a);
        rdchk("baud high", ADDR_BAUD_HI, 8'h0a);
        wr(ADDR_BAUD_LO, 8'h5c);
        chk("baud", 12'ha5c, baud_divisor);
        wr(ADDR_ENABLE, 8'h20);
        chk("empty irq masked", 12'h000, 12'(buffer_empty_irq));
        @(posedge sys_clk);
        global_irq_enable <= 1'b1;
        #1 chk("empty irq", 12'h001, 12'(buffer_empty_irq));
        wr(ADDR_ENABLE, 8'h4d);
        wr(ADDR_DATA, 8'h3c);
        wait_for(0);
        chk("sent nine bits", 12'h13c, 12'(last_tx_char));
        rdchk("tx done", ADDR_STATUS, 8'h60);
        wr(ADDR_STATUS, 8'h40);
        rdchk("tx done cleared", ADDR_STATUS, 8'h20);
        wr(ADDR_DATA, 8'h55);
        wr(ADDR_ENABLE, 8'h44);
        chk("tx still owned", 12'h001, 12'(tx_pin_override));
        wait_for(1);
        chk("pending sent", 12'h155, 12'(last_tx_char));
        wait_for(0);
        @(posedge sys_clk);
        tx_ack <= 1'b1;
        @(posedge sys_clk);
        tx_ack <= 1'b0;
        rdchk("tx done serviced", ADDR_STATUS, 8'h20);
        wr(ADDR_ENABLE, 8'h94);
        send_in(9'h1a5, 1'b0);
        chk("rx irq", 12'h001, 12'(rx_done_irq));
        rdchk("ninth bit", ADDR_ENABLE, 8'h96);
        rdchk("rx data", ADDR_DATA, 8'ha5);
        rdchk("rx empty", ADDR_STATUS, 8'h20);
        wr(ADDR_FORMAT, 8'h26);
        wr(ADDR_ENABLE, 8'h10);
        chk("tx parity", 12'h000, 12'(tx_parity));
        send_in(9'h0c3, 1'b1);
        send_in(9'h03c, 1'b0);
        rdchk("parity error", ADDR_STATUS, 8'ha4);
        rdchk("rx data 2", ADDR_DATA, 8'hc3);
        rdchk("next good", ADDR_STATUS, 8'ha0);
        rdchk("rx data 3", ADDR_DATA, 8'h3c);
        send_in(9'h081, 1'b1);
        rdchk("bad waiting", ADDR_STATUS, 8'ha4);
        wr(ADDR_ENABLE, 8'h00);
        rdchk("flushed", ADDR_STATUS, 8'h20);
        chk("rx released", 12'h000, 12'(rx_pin_override));
        finish_test();
    end
endmodule
`default_nettype wire
